// ### task_file_pkg.sv
// Shared constants and types for the parallel host port task-file decode
package task_file_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int BSY_SET_MAX_NS = 400;
  localparam int BSY_SET_MAX_CYC = BSY_SET_MAX_NS / CLK_PERIOD_NS;
  localparam int RESET_MIN_US = 25;
  localparam int RESET_MIN_CYC = (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Address indexes on the three device address lines
  localparam logic [2:0] IDX_DATA = 3'h0;
  localparam logic [2:0] IDX_ERR_FEAT = 3'h1;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [2:0] IDX_SECNUM = 3'h3;
  localparam logic [2:0] IDX_CYL_LOW = 3'h4;
  localparam logic [2:0] IDX_CYL_HIGH = 3'h5;
  localparam logic [2:0] IDX_DEV_HEAD = 3'h6;
  localparam logic [2:0] IDX_STAT_CMD = 3'h7;
  localparam logic [2:0] IDX_ALT_CTL = 3'h6;
  localparam logic [2:0] IDX_DEV_ADDR = 3'h7;

  // Field positions and reset values
  localparam int STAT_BSY_BIT = 7;
  localparam int DEV_ADDR_FLOAT_BIT = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] DRIVE_NONE = 16'hFFFF;
  localparam logic [15:0] MASK_WORD = 16'hFFFF;
  localparam logic [15:0] MASK_BYTE = 16'h00FF;
  localparam logic [15:0] MASK_DEV_ADDR = 16'h007F;
  localparam logic [15:0] MASK_NONE = 16'h0000;

  // Decoded register selection
  typedef enum logic [3:0] {
    REG_NONE = 4'h0,
    REG_DATA = 4'h1,
    REG_ERROR = 4'h2,
    REG_FEATURES = 4'h3,
    REG_COUNT = 4'h4,
    REG_SECNUM = 4'h5,
    REG_CYL_LOW = 4'h6,
    REG_CYL_HIGH = 4'h7,
    REG_DEV_HEAD = 4'h8,
    REG_STATUS = 4'h9,
    REG_COMMAND = 4'hA,
    REG_ALT_STATUS = 4'hB,
    REG_DEV_CONTROL = 4'hC,
    REG_DEV_ADDR = 4'hD
  } reg_sel_type;

endpackage

// ### task_file_sel_if.sv
// Selection bundle between the host port top and its address decoder
`timescale 1ns/10ps
interface task_file_sel_if;
  import task_file_pkg::*;
  logic cs0_n;
  logic cs1_n;
  logic [2:0] idx;
  reg_sel_type rd_sel;
  reg_sel_type wr_sel;
  logic data_hit;
  modport decoder (input cs0_n, input cs1_n, input idx,
                   output rd_sel, output wr_sel, output data_hit);
  modport user (output cs0_n, output cs1_n, output idx,
                input rd_sel, input wr_sel, input data_hit);
endinterface

// ### pin_sync.sv
// Two-stage synchroniser for a group of host pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pins,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= pins;
      sync_ff <= meta_ff;
    end
  end

  assign synced = sync_ff;

endmodule

// ### task_file_decoder.sv
// Combinational chip-select and index decode of the task file
`timescale 1ns/10ps
module task_file_decoder (
  task_file_sel_if.decoder sel
);
  import task_file_pkg::*;

  // Same map serves reads and writes, only the direction differs
  function automatic reg_sel_type decode(input logic cs0_n, input logic cs1_n,
                                         input logic [2:0] idx, input logic wr);
    reg_sel_type r;
    r = REG_NONE;
    if (cs0_n == cs1_n) begin
      r = REG_NONE;
    end else if (!cs0_n) begin
      case (idx)
        IDX_DATA: r = REG_DATA;
        IDX_ERR_FEAT: r = wr ? REG_FEATURES : REG_ERROR;
        IDX_COUNT: r = REG_COUNT;
        IDX_SECNUM: r = REG_SECNUM;
        IDX_CYL_LOW: r = REG_CYL_LOW;
        IDX_CYL_HIGH: r = REG_CYL_HIGH;
        IDX_DEV_HEAD: r = REG_DEV_HEAD;
        IDX_STAT_CMD: r = wr ? REG_COMMAND : REG_STATUS;
        default: r = REG_NONE;
      endcase
    end else begin
      case (idx)
        IDX_ALT_CTL: r = wr ? REG_DEV_CONTROL : REG_ALT_STATUS;
        IDX_DEV_ADDR: r = wr ? REG_NONE : REG_DEV_ADDR;
        default: r = REG_NONE;
      endcase
    end
    return r;
  endfunction

  // Decode is purely combinational on selects and index
  assign sel.rd_sel = decode(sel.cs0_n, sel.cs1_n, sel.idx, 1'b0);
  assign sel.wr_sel = decode(sel.cs0_n, sel.cs1_n, sel.idx, 1'b1);
  assign sel.data_hit = (sel.rd_sel == REG_DATA);

endmodule

// ### task_file_port.sv
// Host port task-file register block of the disk controller
// Summary of operation
// - Low select reaches all registers except alternate status, control and address.
// - Both selects negated or both asserted: no register read or write.
// - Low select index 0 reads and writes the 16-bit sector buffer path.
// - Index 1: read gives error flags, write loads features.
// - Index 2: reads and writes reach the same sector count.
// - Index 3: sector number, also block address bits 0 to 7.
// - Index 4: cylinder low, also block address bits 8 to 15.
// - Index 5: cylinder high, also block address bits 16 to 23.
// - Index 6: device/head, also carrying block address bits 24 to 27.
// - Index 7: read gives status, write loads a command.
// - High select index 6: read alternate status, write device control.
// - High select at indexes 0 to 5 floats the bus and ignores writes.
// - Legacy drive address is readable; writes there are ignored.
// - Legacy drive address read never drives data bit 7.
// - Wide-transfer indication asserted whenever the data register is addressed outside ECC byte mode.
// - Wide indication stays inactive during byte-wide ECC transfers.
// - Busy status set within 400 ns after reset line goes inactive.
// - Unused bits are left undriven on reads; unused written bits are ignored.
`timescale 1ns/10ps
module task_file_port (
  input wire logic clk,
  input wire logic rst,
  // Host pins
  input wire logic host_cs0_n,
  input wire logic host_cs1_n,
  input wire logic [2:0] host_idx,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_reset_n,
  input wire logic [15:0] dd_in,
  output logic [15:0] dd_out,
  output logic [15:0] dd_oe_n,
  output logic wide_out,
  output logic wide_oe_n,
  // Controller side
  input wire logic ecc_byte_mode,
  input wire logic busy_clear,
  input wire logic [7:0] status_in,
  input wire logic [7:0] error_in,
  input wire logic [7:0] drive_addr_in,
  input wire logic [15:0] buf_rd_data,
  output logic buf_rd_adv,
  output logic [15:0] buf_wr_data,
  output logic buf_wr_stb,
  output logic [7:0] features_out,
  output logic [7:0] sector_count_out,
  output logic [7:0] sector_number_out,
  output logic [7:0] cyl_low_out,
  output logic [7:0] cyl_high_out,
  output logic [7:0] dev_head_out,
  output logic [7:0] command_out,
  output logic command_stb,
  output logic [7:0] dev_control_out,
  output logic hw_reset_stb,
  output logic busy
);
  import task_file_pkg::*;

  localparam int SYNC_W = 24;

  logic [SYNC_W-1:0] sync_q;
  logic s_cs0_n, s_cs1_n, s_rd_n, s_wr_n, s_reset_n;
  logic [2:0] s_idx;
  logic [15:0] s_dd;
  logic rd_active, wr_rise, rd_rise, reset_rise, wide_now;
  logic [15:0] rd_word, rd_mask;
  logic [7:0] status_word;

  logic wr_prev_ff, rd_prev_ff, reset_prev_ff;
  reg_sel_type wr_sel_ff, rd_sel_ff;
  logic [15:0] wr_dat_ff;
  logic [15:0] dd_out_ff, dd_oe_n_ff;
  logic wide_oe_n_ff, wide_out_ff;
  logic buf_rd_adv_ff, buf_wr_stb_ff, command_stb_ff, hw_reset_stb_ff, busy_ff;
  logic [15:0] buf_wr_data_ff;
  logic [7:0] features_ff, sector_count_ff, sector_number_ff, cyl_low_ff;
  logic [7:0] cyl_high_ff, dev_head_ff, command_ff, dev_control_ff;

  task_file_sel_if sel ();

  // Every host pin is synchronised before decode
  pin_sync #(.WIDTH(SYNC_W), .RST_VAL({8'hFF, 16'hFFFF})) u_sync (
    .clk(clk),
    .rst(rst),
    .pins({host_cs0_n, host_cs1_n, host_idx, host_rd_n, host_wr_n,
           host_reset_n, dd_in}),
    .synced(sync_q)
  );

  task_file_decoder u_dec (
    .sel(sel)
  );

  // Unpack synced pins and feed decoder
  assign s_cs0_n = sync_q[23];
  assign s_cs1_n = sync_q[22];
  assign s_idx = sync_q[21:19];
  assign s_rd_n = sync_q[18];
  assign s_wr_n = sync_q[17];
  assign s_reset_n = sync_q[16];
  assign s_dd = sync_q[15:0];
  assign sel.cs0_n = s_cs0_n;
  assign sel.cs1_n = s_cs1_n;
  assign sel.idx = s_idx;

  // Strobe edges; write acts on the rising edge of the write strobe
  assign rd_active = !s_rd_n;
  assign wr_rise = s_wr_n && !wr_prev_ff;
  assign rd_rise = s_rd_n && !rd_prev_ff;
  assign reset_rise = s_reset_n && !reset_prev_ff;
  assign wide_now = sel.data_hit && !ecc_byte_mode;

  // Busy bit overrides the controller's status bit 7
  assign status_word = {busy_ff, status_in[STAT_BSY_BIT-1:0]};

  // Read data and per-bit drive mask
  always_comb begin
    rd_word = WORD_RESET;
    rd_mask = MASK_NONE;
    case (sel.rd_sel)
      REG_DATA: begin
        rd_word = ecc_byte_mode ? {8'h00, buf_rd_data[7:0]} : buf_rd_data;
        rd_mask = ecc_byte_mode ? MASK_BYTE : MASK_WORD;
      end
      REG_ERROR: begin
        rd_word = {8'h00, error_in};
        rd_mask = MASK_BYTE;
      end
      REG_COUNT: begin
        rd_word = {8'h00, sector_count_ff};
        rd_mask = MASK_BYTE;
      end
      REG_SECNUM: begin
        rd_word = {8'h00, sector_number_ff};
        rd_mask = MASK_BYTE;
      end
      REG_CYL_LOW: begin
        rd_word = {8'h00, cyl_low_ff};
        rd_mask = MASK_BYTE;
      end
      REG_CYL_HIGH: begin
        rd_word = {8'h00, cyl_high_ff};
        rd_mask = MASK_BYTE;
      end
      REG_DEV_HEAD: begin
        rd_word = {8'h00, dev_head_ff};
        rd_mask = MASK_BYTE;
      end
      REG_STATUS, REG_ALT_STATUS: begin
        rd_word = {8'h00, status_word};
        rd_mask = MASK_BYTE;
      end
      REG_DEV_ADDR: begin
        // Bit 7 left floating to avoid a shared floppy controller
        rd_word = {9'h000, drive_addr_in[DEV_ADDR_FLOAT_BIT-1:0]};
        rd_mask = MASK_DEV_ADDR;
      end
      default: begin
        rd_word = WORD_RESET;
        rd_mask = MASK_NONE;
      end
    endcase
  end

  // Edge history and write capture while the strobe is low
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      reset_prev_ff <= 1'b1;
      wr_sel_ff <= REG_NONE;
      rd_sel_ff <= REG_NONE;
      wr_dat_ff <= WORD_RESET;
    end else begin
      wr_prev_ff <= s_wr_n;
      rd_prev_ff <= s_rd_n;
      reset_prev_ff <= s_reset_n;
      // Address may move right after the strobe, so hold the last low-phase view
      if (!s_wr_n) begin
        wr_sel_ff <= sel.wr_sel;
        wr_dat_ff <= s_dd;
      end
      if (rd_active) begin
        rd_sel_ff <= sel.rd_sel;
      end
    end
  end

  // Pin drive; enables are low while driving
  always_ff @(posedge clk) begin
    if (rst) begin
      dd_out_ff <= WORD_RESET;
      dd_oe_n_ff <= DRIVE_NONE;
      wide_oe_n_ff <= 1'b1;
      wide_out_ff <= 1'b0;
    end else begin
      dd_out_ff <= rd_word;
      dd_oe_n_ff <= rd_active ? ~rd_mask : DRIVE_NONE;
      wide_oe_n_ff <= !wide_now;
      wide_out_ff <= 1'b0;
    end
  end

  // Register writes on the strobe's rising edge
  always_ff @(posedge clk) begin
    if (rst) begin
      features_ff <= REG_RESET;
      sector_count_ff <= REG_RESET;
      sector_number_ff <= REG_RESET;
      cyl_low_ff <= REG_RESET;
      cyl_high_ff <= REG_RESET;
      dev_head_ff <= REG_RESET;
      command_ff <= REG_RESET;
      dev_control_ff <= REG_RESET;
      buf_wr_data_ff <= WORD_RESET;
    end else if (wr_rise) begin
      case (wr_sel_ff)
        REG_DATA: buf_wr_data_ff <= ecc_byte_mode ? {8'h00, wr_dat_ff[7:0]} : wr_dat_ff;
        REG_FEATURES: features_ff <= wr_dat_ff[7:0];
        REG_COUNT: sector_count_ff <= wr_dat_ff[7:0];
        REG_SECNUM: sector_number_ff <= wr_dat_ff[7:0];
        REG_CYL_LOW: cyl_low_ff <= wr_dat_ff[7:0];
        REG_CYL_HIGH: cyl_high_ff <= wr_dat_ff[7:0];
        REG_DEV_HEAD: dev_head_ff <= wr_dat_ff[7:0];
        REG_COMMAND: command_ff <= wr_dat_ff[7:0];
        REG_DEV_CONTROL: dev_control_ff <= wr_dat_ff[7:0];
        default: ;
      endcase
    end
  end

  // One-cycle strobes toward the controller and the busy flag
  always_ff @(posedge clk) begin
    if (rst) begin
      buf_wr_stb_ff <= 1'b0;
      buf_rd_adv_ff <= 1'b0;
      command_stb_ff <= 1'b0;
      hw_reset_stb_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      buf_wr_stb_ff <= wr_rise && (wr_sel_ff == REG_DATA);
      buf_rd_adv_ff <= rd_rise && (rd_sel_ff == REG_DATA);
      command_stb_ff <= wr_rise && (wr_sel_ff == REG_COMMAND);
      hw_reset_stb_ff <= reset_rise;
      // Reset pin holds busy, so it is already set on release; set beats clear
      if (!s_reset_n) begin
        busy_ff <= 1'b1;
      end else if (busy_clear) begin
        busy_ff <= 1'b0;
      end
    end
  end

  assign dd_out = dd_out_ff;
  assign dd_oe_n = dd_oe_n_ff;
  assign wide_out = wide_out_ff;
  assign wide_oe_n = wide_oe_n_ff;
  assign buf_rd_adv = buf_rd_adv_ff;
  assign buf_wr_data = buf_wr_data_ff;
  assign buf_wr_stb = buf_wr_stb_ff;
  assign features_out = features_ff;
  assign sector_count_out = sector_count_ff;
  assign sector_number_out = sector_number_ff;
  assign cyl_low_out = cyl_low_ff;
  assign cyl_high_out = cyl_high_ff;
  assign dev_head_out = dev_head_ff;
  assign command_out = command_ff;
  assign command_stb = command_stb_ff;
  assign dev_control_out = dev_control_ff;
  assign hw_reset_stb = hw_reset_stb_ff;
  assign busy = busy_ff;

  // Checks on decode, drive and busy behaviour
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_invalid_no_drive: assert property ((rd_active && (s_cs0_n == s_cs1_n)) |=>
    (dd_oe_n_ff == DRIVE_NONE)) else $error("bus driven on invalid select");
  a_high_float: assert property ((rd_active && !s_cs0_n == 1'b0 && !s_cs1_n
    && s_idx < IDX_ALT_CTL) |=> (dd_oe_n_ff == DRIVE_NONE)) else $error("high select drove bus");
  a_data_wide_on: assert property ((sel.data_hit && !ecc_byte_mode) |=>
    !wide_oe_n_ff) else $error("wide indication missing");
  a_ecc_narrow: assert property ((ecc_byte_mode || !sel.data_hit) |=>
    wide_oe_n_ff) else $error("wide indication during byte transfer");
  a_devaddr_bit7: assert property ((rd_active && sel.rd_sel == REG_DEV_ADDR) |=>
    (dd_oe_n_ff[7] && !dd_oe_n_ff[0])) else $error("drive address bit 7 driven");
  a_feature_load: assert property ((wr_rise && wr_sel_ff == REG_FEATURES) |=>
    (features_ff == $past(wr_dat_ff[7:0]))) else $error("features not loaded");
  a_command_strobe: assert property ((wr_rise && wr_sel_ff == REG_COMMAND) |=>
    (command_stb_ff && command_ff == $past(wr_dat_ff[7:0]))) else $error("command lost");
  a_count_stable: assert property ((wr_rise && wr_sel_ff == REG_NONE) |=>
    ($stable(sector_count_ff) && $stable(dev_control_ff))) else $error("ignored write stored");
  a_busy_reset: assert property ($rose(s_reset_n) |-> busy_ff ##1 busy_ff)
    else $error("busy not set after reset release");
  a_status_busy: assert property ((rd_active && sel.rd_sel == REG_STATUS) |=>
    (dd_out_ff[STAT_BSY_BIT] == $past(busy_ff))) else $error("status busy bit wrong");
  a_unused_zero: assert property ((rd_active && sel.rd_sel != REG_DATA) |=>
    (dd_out_ff[15:8] == 8'h00)) else $error("upper byte not zero");

  c_data_read: cover property (rd_active && sel.rd_sel == REG_DATA ##[1:20] rd_rise);
  c_command_write: cover property (command_stb_ff);
  c_reset_busy: cover property ($rose(s_reset_n) ##[1:50] busy_clear);
  c_alt_status: cover property (rd_active && sel.rd_sel == REG_ALT_STATUS);

endmodule

// ### host_adapter_model.sv
// Host adapter model that drives the drive's task-file pins
`timescale 1ns/10ps
module host_adapter_model (
  input wire logic clk,
  output logic cs0_n,
  output logic cs1_n,
  output logic [2:0] idx,
  output logic rd_n,
  output logic wr_n,
  output logic reset_n,
  output logic [15:0] dd_in,
  input wire logic [15:0] dd_out,
  input wire logic [15:0] dd_oe_n,
  input wire logic wide_out,
  input wire logic wide_oe_n
);
  import task_file_pkg::*;
  logic host_drv = 1'b0;
  logic [15:0] host_data = 16'h0000;
  logic [15:0] float_pat = 16'hA5C3;
  logic wide_line;
  // Released bits wander every cycle, so stale data never passes for a read
  always @(posedge clk) float_pat <= ~float_pat;
  assign dd_in = (~dd_oe_n & dd_out) | (dd_oe_n & (host_drv ? host_data : float_pat));
  // Open-drain wide indication, pulled up when nobody sinks it
  assign wide_line = (wide_oe_n === 1'b0) ? wide_out : 1'b1;
  // Select, strobe and reset pins idle high from time zero; index starts at zero
  initial begin
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    idx = 3'h0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    reset_n = 1'b1;
  end
  // Select and index first, then a strobe long enough for the synchronisers
  task automatic wr(input logic c0, input logic c1, input logic [2:0] a,
                    input logic [15:0] d);
    @(posedge clk);
    #1;
    cs0_n = c0;
    cs1_n = c1;
    idx = a;
    host_data = d;
    host_drv = 1'b1;
    @(posedge clk);
    #1;
    wr_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    wr_n = 1'b1;
    // Data and address held past the strobe rise, as a real adapter does
    repeat (3) @(posedge clk);
    #1;
    host_drv = 1'b0;
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Read cycle; returns bus value, enables, wide level and enables after release
  task automatic rd(input logic c0, input logic c1, input logic [2:0] a,
                    output logic [15:0] d, output logic [15:0] oe, output logic w,
                    output logic [15:0] oe_rel);
    @(posedge clk);
    #1;
    cs0_n = c0;
    cs1_n = c1;
    idx = a;
    @(posedge clk);
    #1;
    rd_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    w = wide_line;
    oe = dd_oe_n;
    d = w ? {8'h00, dd_in[7:0]} : dd_in;
    rd_n = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    oe_rel = dd_oe_n;
    cs0_n = 1'b1;
    cs1_n = 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Host-side I/O decode of both blocks; returns {cs0_n, cs1_n, idx}
  function automatic logic [4:0] isa_decode(input logic [9:0] io);
    logic [4:0] p;
    p = {2'b11, io[2:0]};
    // Primary and secondary eight-port blocks take the low select
    if (io[9:3] == 7'h3E || io[9:3] == 7'h2E) p[4] = 1'b0;
    // Alternate-status pairs take the high select
    if (io[9:1] == 9'h1FB || io[9:1] == 9'h1BB) p[3] = 1'b0;
    return p;
  endfunction
  // Hardware reset pulse of the minimum documented width
  task automatic pulse_reset();
    @(posedge clk);
    #1;
    reset_n = 1'b0;
    repeat (RESET_MIN_CYC) @(posedge clk);
    #1;
    reset_n = 1'b1;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the task-file host port
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) begin \
      num_errors++; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb_top;
  import task_file_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cs0_n, cs1_n, rd_n, wr_n, reset_n, wide_out, wide_oe_n;
  logic [2:0] idx;
  logic [15:0] dd_in, dd_out, dd_oe_n, buf_wr_data;
  logic ecc_byte_mode = 1'b0;
  logic busy_clear = 1'b0;
  logic [7:0] status_in = 8'h5A;
  logic [7:0] error_in = 8'h96;
  logic [7:0] drive_addr_in = 8'hFF;
  logic [15:0] buf_rd_data = 16'hC35A;
  logic buf_rd_adv, buf_wr_stb, command_stb, hw_reset_stb, busy;
  logic [7:0] command_out, dev_control_out;
  wire [7:0] reg_out [1:6];
  logic [4:0] isa_p;
  int num_errors = 0;
  int compares = 0;
  int n_wr = 0;
  int n_cmd = 0;
  int n_adv = 0;
  int n_hrst = 0;
  always #(CLK_PERIOD_NS / 2) clk = ~clk;
  host_adapter_model u_host_adapter_model (.clk(clk), .cs0_n(cs0_n), .cs1_n(cs1_n),
    .idx(idx), .rd_n(rd_n), .wr_n(wr_n), .reset_n(reset_n), .dd_in(dd_in),
    .dd_out(dd_out), .dd_oe_n(dd_oe_n), .wide_out(wide_out), .wide_oe_n(wide_oe_n));
  task_file_port u_task_file_port (.clk(clk), .rst(rst), .host_cs0_n(cs0_n),
    .host_cs1_n(cs1_n), .host_idx(idx), .host_rd_n(rd_n), .host_wr_n(wr_n),
    .host_reset_n(reset_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
    .wide_out(wide_out), .wide_oe_n(wide_oe_n), .ecc_byte_mode(ecc_byte_mode),
    .busy_clear(busy_clear), .status_in(status_in), .error_in(error_in),
    .drive_addr_in(drive_addr_in), .buf_rd_data(buf_rd_data), .buf_rd_adv(buf_rd_adv),
    .buf_wr_data(buf_wr_data), .buf_wr_stb(buf_wr_stb), .features_out(reg_out[1]),
    .sector_count_out(reg_out[2]), .sector_number_out(reg_out[3]),
    .cyl_low_out(reg_out[4]), .cyl_high_out(reg_out[5]), .dev_head_out(reg_out[6]),
    .command_out(command_out), .command_stb(command_stb),
    .dev_control_out(dev_control_out), .hw_reset_stb(hw_reset_stb), .busy(busy));
  // Pulse counters, so a doubled or missing strobe shows up
  always @(posedge clk) begin
    if (buf_wr_stb === 1'b1) n_wr++;
    if (command_stb === 1'b1) n_cmd++;
    if (buf_rd_adv === 1'b1) n_adv++;
    if (hw_reset_stb === 1'b1) n_hrst++;
  end
  function automatic logic [7:0] val(int i);
    return 8'(i * 37 + 17);
  endfunction
  // One read cycle with all its comparisons; undriven bits are masked out
  task automatic rd_chk(input logic c0, input logic c1, input logic [2:0] a,
                        input logic [15:0] ed, input logic [15:0] eoe, input logic ew);
    logic [15:0] d;
    logic [15:0] oe;
    logic w;
    logic [15:0] rel;
    u_host_adapter_model.rd(c0, c1, a, d, oe, w, rel);
    `CHK("read enable", eoe, oe)
    `CHK("read data", ed & ~eoe, d & ~eoe)
    `CHK("wide line", ew, w)
    `CHK("release", 16'hFFFF, rel)
  endtask
  task automatic close_out();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected run of under two thousand cycles
  initial begin
    #(CLK_PERIOD_NS * 20000);
    num_errors++;
    $display("ERROR watchdog expected done seen timeout");
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("idle enable", 16'hFFFF, dd_oe_n)
    `CHK("idle wide", 1'b1, wide_oe_n)
    `CHK("busy at reset", 1'b0, busy)
    for (int i = 1; i <= 6; i++) `CHK("reg reset", 8'h00, reg_out[i])
    // Byte registers under the low select; upper write byte must be ignored
    for (int i = 1; i <= 6; i++) begin
      u_host_adapter_model.wr(1'b0, 1'b1, 3'(i), {8'hA5, val(i)});
      `CHK("byte reg", val(i), reg_out[i])
    end
    for (int i = 2; i <= 6; i++) begin
      rd_chk(1'b0, 1'b1, 3'(i), {8'h00, val(i)}, 16'hFF00, 1'b1);
    end
    rd_chk(1'b0, 1'b1, 3'h1, {8'h00, error_in}, 16'hFF00, 1'b1);
    `CHK("features kept", val(1), reg_out[1])
    u_host_adapter_model.wr(1'b0, 1'b1, 3'h7, 16'h00EC);
    `CHK("command", 8'hEC, command_out)
    `CHK("command pulses", 1, n_cmd)
    rd_chk(1'b0, 1'b1, 3'h7, 16'h005A, 16'hFF00, 1'b1);
    // High select: alternate status, control, legacy address
    u_host_adapter_model.wr(1'b1, 1'b0, 3'h6, 16'h0006);
    `CHK("device control", 8'h06, dev_control_out)
    rd_chk(1'b1, 1'b0, 3'h6, 16'h005A, 16'hFF00, 1'b1);
    rd_chk(1'b1, 1'b0, 3'h7, 16'h007F, 16'hFF80, 1'b1);
    // Host I/O decode onto the selects, primary and secondary blocks
    `CHK("io 1F7", 5'h0F, u_host_adapter_model.isa_decode(10'h1F7))
    `CHK("io 377", 5'h17, u_host_adapter_model.isa_decode(10'h377))
    `CHK("io 2F0", 5'h18, u_host_adapter_model.isa_decode(10'h2F0))
    isa_p = u_host_adapter_model.isa_decode(10'h172);
    rd_chk(isa_p[4], isa_p[3], isa_p[2:0], {8'h00, val(2)}, 16'hFF00, 1'b1);
    isa_p = u_host_adapter_model.isa_decode(10'h3F6);
    rd_chk(isa_p[4], isa_p[3], isa_p[2:0], 16'h005A, 16'hFF00, 1'b1);
    for (int i = 0; i <= 5; i++) begin
      rd_chk(1'b1, 1'b0, 3'(i), 16'h0000, 16'hFFFF, 1'b1);
    end
    rd_chk(1'b1, 1'b1, 3'h2, 16'h0000, 16'hFFFF, 1'b1);
    rd_chk(1'b0, 1'b0, 3'h2, 16'h0000, 16'hFFFF, 1'b1);
    // Writes that must not land anywhere
    u_host_adapter_model.wr(1'b1, 1'b1, 3'h2, 16'h0077);
    u_host_adapter_model.wr(1'b0, 1'b0, 3'h2, 16'h0077);
    u_host_adapter_model.wr(1'b1, 1'b0, 3'h2, 16'h0077);
    `CHK("count kept", val(2), reg_out[2])
    u_host_adapter_model.wr(1'b1, 1'b0, 3'h7, 16'h00EE);
    `CHK("command kept", 8'hEC, command_out)
    `CHK("command pulses", 1, n_cmd)
    // Sector buffer path, full width then byte-wide ECC phase
    u_host_adapter_model.wr(1'b0, 1'b1, 3'h0, 16'h1234);
    `CHK("buffer word", 16'h1234, buf_wr_data)
    `CHK("buffer pulses", 1, n_wr)
    rd_chk(1'b0, 1'b1, 3'h0, 16'hC35A, 16'h0000, 1'b0);
    `CHK("advance pulses", 1, n_adv)
    ecc_byte_mode = 1'b1;
    u_host_adapter_model.wr(1'b0, 1'b1, 3'h0, 16'hBEEF);
    `CHK("ecc byte", 16'h00EF, buf_wr_data)
    rd_chk(1'b0, 1'b1, 3'h0, 16'h005A, 16'hFF00, 1'b1);
    ecc_byte_mode = 1'b0;
    // Hardware reset: busy set, task file kept, then cleared by the controller
    u_host_adapter_model.pulse_reset();
    repeat (BSY_SET_MAX_CYC) @(posedge clk);
    #1;
    `CHK("busy after reset", 1'b1, busy)
    `CHK("reset pulses", 1, n_hrst)
    `CHK("count after reset", val(2), reg_out[2])
    rd_chk(1'b0, 1'b1, 3'h7, 16'h00DA, 16'hFF00, 1'b1);
    busy_clear = 1'b1;
    @(posedge clk);
    #1;
    busy_clear = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("busy cleared", 1'b0, busy)
    close_out();
  end
endmodule
